// [design/fme_seq.sv]
// flash mass erase and row program sequencer, top module
`timescale 1ns/100ps
`default_nettype none
module fme_seq #(
   parameter int RECOVERY_CYCLES = fme_pkg::RECOVERY_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   // control bit writes from software
   input wire logic i_ctrl_wr,                       // write strobe for control bits
   input wire logic i_program_select,                // program select value written
   input wire logic i_erase_select,                  // erase select value written
   input wire logic i_mass_select,                   // mass select value written
   input wire logic i_high_voltage_enable,           // high voltage value written
   // array accesses from software
   input wire logic i_arr_wr,                        // write strobe into array space
   input wire logic i_arr_rd,                        // read strobe into array space
   input wire logic [fme_pkg::ADDR_W-1:0] i_arr_addr, // access address
   input wire logic [fme_pkg::DATA_W-1:0] i_arr_wdata, // write data
   input wire logic [fme_pkg::DATA_W-1:0] i_protect_byte, // stored block protect byte
   // mode inputs from the system
   input wire logic i_monitor_insecure,              // monitor mode with security failed
   input wire logic i_wait_mode,                     // processor in wait mode
   input wire logic i_stop_mode,                     // processor in stop mode
   // control bit readback
   output logic o_program_select,
   output logic o_erase_select,
   output logic o_mass_select,
   output logic o_high_voltage_enable,
   // array side
   output logic o_pump_on,                           // charge pump drive
   output logic o_array_prog,                        // program one byte pulse
   output logic o_array_erase,                       // erase active level
   output logic o_array_mass,                        // whole array erase when erasing
   output logic [fme_pkg::ADDR_W-1:0] o_latch_addr,  // latched address
   output logic [fme_pkg::DATA_W-1:0] o_latch_data,  // latched data
   output logic o_standby,                           // array in standby
   output logic o_read_ready,                        // array readable
   output logic o_seq_error                          // sticky refused-step flag
);
   import fme_pkg::*;

   // all registered state of the sequencer
   typedef struct packed {
      fme_state_e state;
      logic program_select;
      logic ers;
      logic mas;
      logic hv;
      logic prog_pulse;
      logic [ADDR_W-1:0] laddr;
      logic [DATA_W-1:0] ldata;
      logic standby;
      logic ready;
      logic err;
      logic [RCV_W-1:0] rcv;
   } fme_seq_s;

   fme_seq_s cur_ff;
   fme_seq_s nxt_cur;
   fme_if rl ();           // link to the row latch
   logic protected_any;    // protect byte shows any protection
   logic low_power;        // wait or stop requested

   // row latch checks that program writes stay in one row
   fme_row_latch u_row (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .bus(rl.chk)
   );

   // protection and power decoding
   always_comb begin
      protected_any = (i_protect_byte != PROTECT_NONE);
      low_power = i_wait_mode || i_stop_mode;
   end

   // next-state logic
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.prog_pulse = 1'b0;
      rl.wr = 1'b0;
      rl.addr = i_arr_addr;
      rl.clear = 1'b0;
      if (low_power) begin
         // standby: with a select bit set, every control to the array goes inactive
         nxt_cur.standby = (cur_ff.program_select || cur_ff.ers || cur_ff.standby);
         if (cur_ff.program_select || cur_ff.ers) begin
            nxt_cur.hv = 1'b0;
            nxt_cur.program_select = 1'b0;
            nxt_cur.ers = 1'b0;
            nxt_cur.mas = 1'b0;
            nxt_cur.state = FME_IDLE;
            rl.clear = 1'b1;
         end
      end else begin
         nxt_cur.standby = 1'b0;
         // control bit writes
         if (i_ctrl_wr) begin
            // interlock: a write setting both selects is refused whole
            if (i_program_select && i_erase_select) begin
               nxt_cur.err = 1'b1;
            end else begin
               nxt_cur.program_select = i_program_select && !cur_ff.ers;
               nxt_cur.ers = i_erase_select && !cur_ff.program_select;
               nxt_cur.mas = i_mass_select;
               if (i_high_voltage_enable && !cur_ff.hv) begin
                  // voltage on only after the full sequence and with no protection
                  if ((cur_ff.program_select || cur_ff.ers) && cur_ff.state == FME_LATCHED
                      && !protected_any) begin
                     nxt_cur.hv = 1'b1;
                     nxt_cur.state = FME_HV;
                  end else begin
                     nxt_cur.err = 1'b1;
                  end
               end else if (!i_high_voltage_enable && cur_ff.hv) begin
                  nxt_cur.hv = 1'b0;
                  nxt_cur.state = FME_RECOVER;
                  nxt_cur.rcv = RCV_W'(RECOVERY_CYCLES);
                  nxt_cur.ready = 1'b0;
               end
               // selecting an operation arms the sequence and latching
               if (cur_ff.state == FME_IDLE && (nxt_cur.program_select || nxt_cur.ers)
                   && !cur_ff.program_select && !cur_ff.ers) begin
                  nxt_cur.state = FME_ARMED;
                  rl.clear = 1'b1;
               end
               // dropping the select before voltage abandons the sequence
               if (!nxt_cur.program_select && !nxt_cur.ers && !cur_ff.hv && cur_ff.state != FME_RECOVER) begin
                  nxt_cur.state = FME_IDLE;
                  rl.clear = 1'b1;
               end
            end
         end
         // protect byte read step
         if (i_arr_rd && i_arr_addr == PROTECT_ADDR && cur_ff.state == FME_ARMED) begin
            nxt_cur.state = FME_CHECKED;
         end
         // array writes
         if (i_arr_wr) begin
            if (!cur_ff.program_select && !cur_ff.ers) begin
               // nothing selected: write ignored
            end else if (cur_ff.state == FME_CHECKED) begin
               // latch write: protect byte when insecure monitor erasing
               if (rl.in_array
                   && (!(i_monitor_insecure && cur_ff.ers) || i_arr_addr == PROTECT_ADDR)) begin
                  nxt_cur.laddr = i_arr_addr;
                  nxt_cur.ldata = i_arr_wdata;
                  nxt_cur.state = FME_LATCHED;
                  rl.wr = cur_ff.program_select;
               end else begin
                  nxt_cur.err = 1'b1;
               end
            end else if (cur_ff.state == FME_HV && cur_ff.program_select) begin
               // byte write must fall in the latched row
               if (rl.same_row && rl.in_array) begin
                  nxt_cur.laddr = i_arr_addr;
                  nxt_cur.ldata = i_arr_wdata;
                  nxt_cur.prog_pulse = 1'b1;
               end else begin
                  nxt_cur.err = 1'b1;
               end
            end
         end
         // read recovery countdown
         if (cur_ff.state == FME_RECOVER && !(i_ctrl_wr && i_high_voltage_enable)) begin
            if (cur_ff.rcv <= RCV_W'(1)) begin
               nxt_cur.state = FME_IDLE;
               nxt_cur.ready = 1'b1;
               rl.clear = 1'b1;
            end else begin
               nxt_cur.rcv = cur_ff.rcv - RCV_W'(1);
            end
         end
      end
   end

   // state register, reset to read mode with pump off
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         cur_ff <= '{state: FME_IDLE, ready: 1'b1, default: '0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // outputs straight from the state register
   assign o_program_select = cur_ff.program_select;
   assign o_erase_select = cur_ff.ers;
   assign o_mass_select = cur_ff.mas;
   assign o_high_voltage_enable = cur_ff.hv;
   assign o_pump_on = cur_ff.hv;
   assign o_array_prog = cur_ff.prog_pulse;
   assign o_array_erase = cur_ff.ers && cur_ff.hv;
   assign o_array_mass = cur_ff.mas && cur_ff.ers;
   assign o_latch_addr = cur_ff.laddr;
   assign o_latch_data = cur_ff.ldata;
   assign o_standby = cur_ff.standby;
   assign o_read_ready = cur_ff.ready;
   assign o_seq_error = cur_ff.err;
endmodule
`default_nettype wire

// [design/fme_pkg.sv]
// package of constants and types for the flash mass erase and row program sequencer
package fme_pkg;
   // address and data widths of the processor bus
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // row geometry: 64 bytes per row, row number is address bits 6 and up
   localparam int ROW_BYTES = 64;
   localparam int ROW_LSB = 6;
   // array address window (user memory up to top vectors)
   localparam logic [15:0] ARRAY_LO = 16'h8000;
   localparam logic [15:0] ARRAY_HI = 16'hFFFF;
   // location of the block protect byte
   localparam logic [15:0] PROTECT_ADDR = 16'hFF80;
   // protect byte value meaning no protection
   localparam logic [7:0] PROTECT_NONE = 8'hFF;
   // clock period and recovery interval
   localparam int CLK_PERIOD_NS = 10;
   localparam int READ_RECOVERY_NS = 1000;
   localparam int RECOVERY_CYC = (READ_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCV_W = 8;

   // sequencer states
   typedef enum logic [2:0] {
      FME_IDLE = 3'b000,  // read mode
      FME_ARMED = 3'b001, // select bit set, waiting for protect read
      FME_CHECKED = 3'b010, // protect read done, waiting latch write
      FME_LATCHED = 3'b011, // address latched, high voltage may be set
      FME_HV = 3'b100,    // high voltage on
      FME_RECOVER = 3'b101 // read recovery after high voltage off
   } fme_state_e;
endpackage

// [design/fme_if.sv]
// bundle carrying array accesses from the sequencer to the row checker
`timescale 1ns/100ps
`default_nettype none
interface fme_if;
   import fme_pkg::*;
   logic wr;                      // array write seen this cycle
   logic [ADDR_W-1:0] addr;       // address of that write
   logic clear;                   // forget the latched row
   logic latched;                 // a row is held
   logic same_row;                // current write lies in the held row
   logic in_array;                // current address lies in the array
   modport seq (output wr, addr, clear, input latched, same_row, in_array);
   modport chk (input wr, addr, clear, output latched, same_row, in_array);
endinterface
`default_nettype wire

// [design/fme_row_latch.sv]
// row latch: holds the row of the first array write and compares later writes against it
`timescale 1ns/100ps
`default_nettype none
module fme_row_latch (
   input wire logic i_core_clk,
   input wire logic i_srst,
   fme_if.chk bus
);
   import fme_pkg::*;

   // all state of the latch
   typedef struct packed {
      logic held;                         // row captured
      logic [ADDR_W-ROW_LSB-1:0] row;     // captured row number
   } fme_row_s;

   fme_row_s cur_ff;
   fme_row_s nxt_cur;

   // combinational outputs of the comparison
   always_comb begin
      bus.latched = cur_ff.held;
      bus.in_array = (bus.addr >= ARRAY_LO) && (bus.addr <= ARRAY_HI);
      bus.same_row = cur_ff.held && (bus.addr[ADDR_W-1:ROW_LSB] == cur_ff.row);
   end

   // next state: capture on first write, drop on clear
   always_comb begin
      nxt_cur = cur_ff;
      if (bus.clear) begin
         nxt_cur.held = 1'b0;
      end else if (bus.wr && !cur_ff.held) begin
         nxt_cur.held = 1'b1;
         nxt_cur.row = bus.addr[ADDR_W-1:ROW_LSB];
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end
endmodule
`default_nettype wire

// [verif/fme_seq_chk.sv]
// assertion checker watching the flash sequencer top ports
`timescale 1ns/100ps
`default_nettype none
module fme_seq_chk #(
   parameter int RECOVERY_CYCLES = 100
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_arr_wr,
   input wire logic [15:0] i_arr_addr,
   input wire logic [7:0] i_arr_wdata,
   input wire logic [7:0] i_protect_byte,
   input wire logic i_wait_mode,
   input wire logic i_stop_mode,
   input wire logic o_program_select,
   input wire logic o_erase_select,
   input wire logic o_high_voltage_enable,
   input wire logic o_pump_on,
   input wire logic o_array_prog,
   input wire logic o_array_erase,
   input wire logic o_array_mass,
   input wire logic [15:0] o_latch_addr,
   input wire logic [7:0] o_latch_data,
   input wire logic o_standby,
   input wire logic o_read_ready,
   input wire logic o_seq_error
);
   // slack of two edges around the recovery count
   localparam int RC_MAX = RECOVERY_CYCLES + 2;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   // some operation is selected
   wire logic any_sel = o_program_select | o_erase_select;
   // voltage dropped outside standby, then a bounded recovery
   sequence s_hv_off; $fell(o_high_voltage_enable) && !o_standby; endsequence
   sequence s_recover; !o_read_ready ##[1:RC_MAX] o_read_ready; endsequence
   property p_recover; s_hv_off |-> s_recover; endproperty
   property p_pump; o_pump_on == o_high_voltage_enable; endproperty
   property p_excl; !(o_program_select && o_erase_select); endproperty
   property p_hv_sel; $rose(o_high_voltage_enable) |-> any_sel && $past(i_protect_byte) == 8'hFF;
   endproperty
   property p_mass; $rose(o_array_erase) && o_array_mass |-> $past(i_protect_byte) == 8'hFF;
   endproperty
   property p_erase; o_array_erase == (o_erase_select && o_high_voltage_enable) &&
      (!o_array_mass || o_erase_select); endproperty
   property p_standby; (i_wait_mode || i_stop_mode) && any_sel |=> o_standby && !any_sel && !o_pump_on;
   endproperty
   property p_quiet; o_standby |-> !o_pump_on && !o_array_prog && !o_array_erase; endproperty
   property p_prog; o_array_prog |-> $past(i_arr_wr) && $past(o_program_select) &&
      o_latch_addr == $past(i_arr_addr) && o_latch_data == $past(i_arr_wdata); endproperty
   property p_reset; $fell(i_srst) |-> !any_sel && !o_high_voltage_enable && o_read_ready;
   endproperty
   a_recover: assert property (p_recover) else $error("read ready not restored");
   a_pump: assert property (p_pump) else $error("pump differs from voltage bit");
   a_excl: assert property (p_excl) else $error("both selects set");
   a_hv_sel: assert property (p_hv_sel) else $error("voltage set wrongly");
   a_mass: assert property (p_mass) else $error("mass erase while protected");
   a_erase: assert property (p_erase) else $error("erase outputs wrong");
   a_standby: assert property (p_standby) else $error("no standby");
   a_quiet: assert property (p_quiet) else $error("control active in standby");
   a_prog: assert property (p_prog) else $error("bad program pulse");
   a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule
bind fme_seq fme_seq_chk #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (.*);
`default_nettype wire

// [verif/fme_sw.sv]
// software model issuing control writes, protect reads and array writes
`timescale 1ns/100ps
`default_nettype none
module fme_sw #(
   parameter int US_CYC = 100
) (
   input wire logic i_core_clk,
   input wire logic i_read_ready,
   output var logic o_ctrl_wr,
   output var logic [3:0] o_ctrl,
   output var logic o_arr_wr,
   output var logic o_arr_rd,
   output var logic [15:0] o_addr,
   output var logic [7:0] o_wdata
);
   import fme_pkg::*;
   // code runs from outside the array with interrupts off
   initial begin
      {o_ctrl_wr, o_arr_wr, o_arr_rd} = 3'b000;
      {o_ctrl, o_addr, o_wdata} = 28'h0;
   end
   // one strobed cycle; released lines flip so no stale value is seen
   task automatic cyc(input logic c, input logic r, input logic w, input logic [15:0] a,
         input logic [7:0] d, input logic [3:0] v);
      // one idle edge first, so back-to-back calls never reassign in one step
      @(posedge i_core_clk);
      #1;
      {o_ctrl_wr, o_arr_rd, o_arr_wr, o_addr, o_wdata, o_ctrl} = {c, r, w, a, d, v};
      @(posedge i_core_clk);
      #1;
      {o_ctrl_wr, o_arr_rd, o_arr_wr, o_addr, o_wdata, o_ctrl} = {3'b000, ~a, ~d, ~v};
   endtask
   // wait n microseconds at the scaled rate
   task automatic wt(input int n);
      repeat (n * US_CYC) @(posedge i_core_clk);
      #1;
   endtask
   // select, protect read, latch write, setup wait, voltage on
   task automatic open_op(input logic [3:0] sel, input logic [15:0] a);
      cyc(1'b1, 1'b0, 1'b0, a, 8'h00, sel);
      cyc(1'b0, 1'b1, 1'b0, PROTECT_ADDR, 8'h00, 4'h0);
      cyc(1'b0, 1'b0, 1'b1, a, 8'h5A, 4'h0);
      wt(10);
      cyc(1'b1, 1'b0, 1'b0, a, 8'h00, sel | 4'h1);
      if (sel[3])
         wt(5);
   endtask
   // select off, hold wait, voltage off, wait for recovery
   task automatic close_op(input logic prog);
      if (!prog)
         wt(4000);
      cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'h1);
      wt(prog ? 5 : 100);
      cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'h0);
      for (int i = 0; i < 64 && i_read_ready !== 1'b1; i++)
         @(posedge i_core_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// [verif/test_flash_mass_erase_and_row_program.sv]
// self-checking bench for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module test_flash_mass_erase_and_row_program;
   import fme_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_srst;           // reset, driven by the reset task
   logic [7:0] prot;       // stored protect byte seen by the sequencer
   logic mon;              // insecure monitor mode level
   logic wmode;            // wait mode level
   logic smode;            // stop mode level
   int error_cnt = 0;
   int total_checks = 0;
   wire logic c_wr, a_wr, a_rd, ps, es, ms, hv, pump, aprog, aer, amass, stby, rdy, err;
   wire logic [3:0] c_v;
   wire logic [15:0] addr, la;
   wire logic [7:0] wd, ld;
   // 100 MHz clock
   always #5 i_core_clk = ~i_core_clk;
   fme_sw #(.US_CYC(1)) sw (.i_core_clk(i_core_clk), .i_read_ready(rdy), .o_ctrl_wr(c_wr),
      .o_ctrl(c_v), .o_arr_wr(a_wr), .o_arr_rd(a_rd), .o_addr(addr), .o_wdata(wd));
   fme_seq #(.RECOVERY_CYCLES(4)) DUT (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ctrl_wr(c_wr),
      .i_program_select(c_v[3]), .i_erase_select(c_v[2]), .i_mass_select(c_v[1]),
      .i_high_voltage_enable(c_v[0]), .i_arr_wr(a_wr), .i_arr_rd(a_rd), .i_arr_addr(addr),
      .i_arr_wdata(wd), .i_protect_byte(prot), .i_monitor_insecure(mon), .i_wait_mode(wmode),
      .i_stop_mode(smode), .o_program_select(ps), .o_erase_select(es), .o_mass_select(ms),
      .o_high_voltage_enable(hv), .o_pump_on(pump), .o_array_prog(aprog), .o_array_erase(aer),
      .o_array_mass(amass), .o_latch_addr(la), .o_latch_data(ld), .o_standby(stby),
      .o_read_ready(rdy), .o_seq_error(err));
   // two-cycle reset, released just after an edge
   task automatic rst();
      i_srst = 1'b1;
      repeat (2) @(posedge i_core_clk);
      #1;
      i_srst = 1'b0;
   endtask
   // mass or page erase run to the end
   task automatic t_erase(input logic m);
      rst();
      sw.open_op({2'b01, m, 1'b0}, ARRAY_LO);
      `CHK({hv, pump, aer}, 3'b111)
      `CHK(amass, m)
      sw.close_op(1'b0);
      `CHK({rdy, err, hv}, 3'b100)
   endtask
   // program two bytes at the row ends, then one outside the row
   task automatic t_program();
      logic [15:0] ta [3];
      ta = '{16'h8040, 16'h807F, 16'h8080};
      rst();
      sw.open_op(4'b1000, 16'h8040);
      for (int i = 0; i < 3; i++) begin
         sw.cyc(1'b0, 1'b0, 1'b1, ta[i], 8'h3C, 4'h0);
         `CHK({aprog, err}, (i < 2) ? 2'b10 : 2'b01)
         if (i < 2)
            `CHK({la, ld}, {ta[i], 8'h3C})
         sw.wt(30);
      end
      sw.close_op(1'b1);
      `CHK({rdy, ps}, 2'b10)
   endtask
   // protected memory refuses high voltage for erase and program
   task automatic t_protect();
      for (int k = 0; k < 2; k++) begin
         rst();
         prot = k ? 8'h00 : 8'hFE;
         sw.open_op(k ? 4'b1000 : 4'b0110, 16'h8040);
         `CHK({hv, pump, err}, 3'b001)
      end
      prot = 8'hFF;
   endtask
   // select interlock, unselected writes and lone voltage writes
   task automatic t_interlock();
      rst();
      sw.cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'b0100);
      sw.cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'b1000);
      `CHK(ps, 1'b0)
      rst();
      sw.cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'b1100);
      `CHK({ps, es, err}, 3'b001)
      rst();
      sw.cyc(1'b0, 1'b0, 1'b1, 16'h8100, 8'h00, 4'h0);
      `CHK({aprog, la, ld}, 25'h0)
      sw.cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'h1);
      `CHK(hv, 1'b0)
      // voltage request that skips the protect read and latch steps
      rst();
      sw.cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'b1000);
      sw.cyc(1'b1, 1'b0, 1'b0, ARRAY_LO, 8'h00, 4'b1001);
      `CHK({hv, err}, 2'b01)
   endtask
   // wait mode in read mode, wait and stop modes in mid-program
   task automatic t_standby();
      rst();
      wmode = 1'b1;
      sw.wt(3);
      `CHK({stby, rdy}, 2'b01)
      wmode = 1'b0;
      for (int k = 0; k < 2; k++) begin
         rst();
         sw.open_op(4'b1000, 16'h8040);
         {wmode, smode} = k ? 2'b01 : 2'b10;
         sw.wt(1);
         `CHK({stby, pump, ps, hv}, 4'b1000)
         {wmode, smode} = 2'b00;
      end
   endtask
   // insecure monitor erase latches only at the protect byte
   task automatic t_monitor();
      for (int k = 0; k < 2; k++) begin
         rst();
         mon = 1'b1;
         sw.open_op(4'b0110, k ? PROTECT_ADDR : ARRAY_LO);
         `CHK(err, k == 0)
         mon = 1'b0;
      end
   endtask
   // counts and verdict, then end of run
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence
   initial begin
      {prot, mon, wmode, smode} = {PROTECT_NONE, 3'b000};
      rst();
      `CHK({ps, es, ms, hv, pump, stby, err, rdy}, 8'h01)
      t_erase(1'b1);
      t_erase(1'b0);
      t_program();
      t_protect();
      t_interlock();
      t_standby();
      t_monitor();
      complete_run();
   end
   // watchdog about three times the expected run of some ten thousand cycles
   initial begin
      #300000;
      error_cnt++;
      complete_run();
   end
endmodule
`default_nettype wire
